// ==== rtl/capsc_card.sv ====
`timescale 1ns/1ps
`include "capsc_cfg.svh"
module capsc_card (
	input wire logic clk,
	input wire logic rst,
	capsc_if.card link,
	// Command layout announced with the header
	input wire logic has_lc,
	input wire logic has_le,
	output logic [7:0] cla,
	output logic [7:0] ins,
	output logic [7:0] p1,
	output logic [7:0] p2,
	output logic [7:0] lc,
	output logic [7:0] le,
	output logic hdr_valid,
	output logic [7:0] cmd_byte,
	output logic cmd_byte_valid,
	// Application verdict on the header
	input wire logic cla_ok,
	input wire logic cla_chan_ok,
	input wire logic cla_sm_ok,
	input wire logic ins_ok,
	input wire logic p1p2_ok,
	input wire logic toolkit_busy,
	// Application result after the data field
	input wire logic done,
	input wire capsc_pkg::capsc_outcome_e outcome,
	input wire logic [7:0] detail,
	input wire logic [8:0] rsp_len,
	input wire logic [7:0] rsp_byte,
	output logic rsp_byte_take,
	output logic busy
);

	typedef enum logic [6:0] {
		S_HDR = 7'b0000001,
		S_LC = 7'b0000010,
		S_DATA = 7'b0000100,
		S_LE = 7'b0001000,
		S_EXEC = 7'b0010000,
		S_RDATA = 7'b0100000,
		S_SW = 7'b1000000
	} capsc_state_e;

	capsc_state_e st_q;
	logic [1:0] hcnt_q;
	logic [8:0] cnt_q;
	logic [7:0] sw1_q;
	logic [7:0] sw2_q;
	logic sw_sel_q;
	logic [8:0] rlen_q;
	logic early_q;
	logic beat;
	logic out_beat;

	function automatic logic [15:0] code(input capsc_pkg::capsc_outcome_e o,
		input logic [7:0] d, input logic [8:0] n);
		logic [15:0] r;
		r = {`CAPSC_SW1_OK, `CAPSC_SW2_NONE};
		unique case (o)
		capsc_pkg::CAPSC_OK: r = {`CAPSC_SW1_OK, `CAPSC_SW2_NONE};
		capsc_pkg::CAPSC_OK_PEND: r = {`CAPSC_SW1_PEND, d};
		capsc_pkg::CAPSC_OK_SESS: r = {`CAPSC_SW1_SESS, d};
		capsc_pkg::CAPSC_BUSY: r = {`CAPSC_SW1_BUSY, `CAPSC_SW2_NONE};
		capsc_pkg::CAPSC_WARN_NONE: r = {`CAPSC_SW1_WARN, `CAPSC_SW2_NONE};
		capsc_pkg::CAPSC_WARN_CORRUPT: r = {`CAPSC_SW1_WARN, `CAPSC_SW2_MEM};
		capsc_pkg::CAPSC_WARN_EOF: r = {`CAPSC_SW1_WARN, `CAPSC_SW2_EOF};
		capsc_pkg::CAPSC_WARN_INVAL: r = {`CAPSC_SW1_WARN, `CAPSC_SW2_INVAL};
		capsc_pkg::CAPSC_WARN_TERM: r = {`CAPSC_SW1_WARN, `CAPSC_SW2_TERM};
		capsc_pkg::CAPSC_MORE_AVAIL: r = {`CAPSC_SW1_WARN, `CAPSC_SW2_MORE};
		capsc_pkg::CAPSC_MORE_AVAIL_PEND:
			r = {`CAPSC_SW1_WARN, `CAPSC_SW2_MORE_PEND};
		capsc_pkg::CAPSC_RESP_AVAIL: r = {`CAPSC_SW1_WARN, `CAPSC_SW2_RESP};
		capsc_pkg::CAPSC_MORE_EXP: r = {`CAPSC_SW1_WARN2, `CAPSC_SW2_MORE};
		capsc_pkg::CAPSC_MORE_EXP_PEND:
			r = {`CAPSC_SW1_WARN2, `CAPSC_SW2_MORE_PEND};
		capsc_pkg::CAPSC_RETRY:
			r = {`CAPSC_SW1_WARN2, `CAPSC_SW2_RETRY, d[3:0]};
		capsc_pkg::CAPSC_EXEC_KEEP:
			r = {`CAPSC_SW1_EXEC_KEEP, `CAPSC_SW2_NONE};
		capsc_pkg::CAPSC_EXEC_CHG: r = {`CAPSC_SW1_EXEC_CHG, `CAPSC_SW2_NONE};
		capsc_pkg::CAPSC_EXEC_MEM: r = {`CAPSC_SW1_EXEC_CHG, `CAPSC_SW2_MEM};
		capsc_pkg::CAPSC_LEN: r = {`CAPSC_SW1_LEN, d};
		capsc_pkg::CAPSC_P1P2: r = {`CAPSC_SW1_P1P2, `CAPSC_SW2_NONE};
		capsc_pkg::CAPSC_TECH: r = {`CAPSC_SW1_TECH, d};
		capsc_pkg::CAPSC_CLAF: r = {`CAPSC_SW1_CLAF, d};
		capsc_pkg::CAPSC_NALLOW: r = {`CAPSC_SW1_NALLOW, d};
		capsc_pkg::CAPSC_PARAM: r = {`CAPSC_SW1_PARAM, d};
		default: r = {`CAPSC_SW1_TECH, `CAPSC_SW2_NONE};
		endcase
		// Pending length is the response length, not the caller's detail
		if (o == capsc_pkg::CAPSC_OK_PEND) begin
			r[7:0] = n[7:0];
		end
		return r;
	endfunction

	assign beat = link.cmd_valid && link.cmd_ready;
	assign out_beat = link.rsp_valid && link.rsp_ready;
	assign link.cmd_ready = (st_q == S_HDR) || (st_q == S_LC) ||
		(st_q == S_DATA) || (st_q == S_LE);
	assign link.rsp_valid = (st_q == S_RDATA) || (st_q == S_SW);
	assign link.rsp_data = (st_q == S_RDATA) ? rsp_byte :
		(sw_sel_q ? sw2_q : sw1_q);
	assign link.rsp_last = (st_q == S_SW) && sw_sel_q;
	assign rsp_byte_take = (st_q == S_RDATA) && out_beat;
	assign cmd_byte = link.cmd_data;
	assign cmd_byte_valid = (st_q == S_DATA) && beat;
	assign busy = (st_q != S_HDR);

	////////////////////////////////////////////////////////////////////////
	// Header capture
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cla <= `CAPSC_PARAM_UNUSED;
			ins <= `CAPSC_PARAM_UNUSED;
			p1 <= `CAPSC_PARAM_UNUSED;
			p2 <= `CAPSC_PARAM_UNUSED;
			lc <= `CAPSC_PARAM_UNUSED;
			le <= `CAPSC_PARAM_UNUSED;
			hcnt_q <= 2'h0;
		end else if (beat) begin
			if (st_q == S_HDR) begin
				unique case (hcnt_q)
				2'h0: cla <= link.cmd_data;
				2'h1: ins <= link.cmd_data;
				2'h2: p1 <= link.cmd_data;
				2'h3: p2 <= link.cmd_data;
				endcase
				hcnt_q <= hcnt_q + 2'h1;
				// Fresh command, absent lengths read as zero
				if (hcnt_q == 2'h0) begin
					lc <= `CAPSC_PARAM_UNUSED;
					le <= `CAPSC_PARAM_UNUSED;
				end
			end
			if (st_q == S_LC) begin
				lc <= link.cmd_data;
			end
			if (st_q == S_LE) begin
				le <= link.cmd_data;
			end
		end
	end

	assign hdr_valid = (st_q == S_EXEC);

	////////////////////////////////////////////////////////////////////////
	// Sequencing
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_q <= S_HDR;
			cnt_q <= 9'h000;
			early_q <= 1'b0;
		end else begin
			unique case (st_q)
			S_HDR: if (beat && hcnt_q == 2'h3) begin
				st_q <= has_lc ? S_LC : (has_le ? S_LE : S_EXEC);
				early_q <= 1'b0;
			end
			S_LC: if (beat) begin
				cnt_q <= {1'b0, link.cmd_data};
				if (link.cmd_data == 8'h00) begin
					// Zero Lc is outside 1..255: wrong length
					early_q <= 1'b1;
					st_q <= has_le ? S_LE : S_EXEC;
				end else begin
					st_q <= S_DATA;
				end
			end
			S_DATA: if (beat) begin
				cnt_q <= cnt_q - 9'h001;
				if (cnt_q == 9'h001) begin
					st_q <= has_le ? S_LE : S_EXEC;
				end
			end
			S_LE: if (beat) begin
				st_q <= S_EXEC;
			end
			S_EXEC: if (!cla_ok || !cla_chan_ok || !cla_sm_ok || !ins_ok ||
				!p1p2_ok || toolkit_busy || early_q || done) begin
				st_q <= (rlen_d_nonzero() ? S_RDATA : S_SW);
				cnt_q <= rlen_d();
			end
			S_RDATA: if (out_beat) begin
				cnt_q <= cnt_q - 9'h001;
				if (cnt_q == 9'h001) begin
					st_q <= S_SW;
				end
			end
			S_SW: if (out_beat && sw_sel_q) begin
				st_q <= S_HDR;
			end
			default: st_q <= S_HDR;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Status choice and response length
	function automatic logic app_path();
		return cla_ok && cla_chan_ok && cla_sm_ok && ins_ok && p1p2_ok &&
			!toolkit_busy && !early_q;
	endfunction

	function automatic logic [8:0] rlen_d();
		logic [8:0] cap;
		cap = (le == 8'h00) ? `CAPSC_LE_FULL : {1'b0, le};
		if (!app_path() || !has_le) begin
			return 9'h000;
		end
		return (rsp_len > cap) ? cap : rsp_len;
	endfunction

	function automatic logic rlen_d_nonzero();
		return rlen_d() != 9'h000;
	endfunction

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sw1_q <= `CAPSC_SW1_OK;
			sw2_q <= `CAPSC_SW2_NONE;
			sw_sel_q <= 1'b0;
			rlen_q <= 9'h000;
		end else begin
			if (st_q == S_EXEC) begin
				sw_sel_q <= 1'b0;
				rlen_q <= rlen_d();
				// First failing check wins
				if (!cla_ok) begin
					{sw1_q, sw2_q} <= {`CAPSC_SW1_CLA, `CAPSC_SW2_NONE};
				end else if (!cla_chan_ok) begin
					{sw1_q, sw2_q} <= {`CAPSC_SW1_CLAF, `CAPSC_SW2_CHAN};
				end else if (!cla_sm_ok) begin
					{sw1_q, sw2_q} <= {`CAPSC_SW1_CLAF, `CAPSC_SW2_SM};
				end else if (!ins_ok) begin
					{sw1_q, sw2_q} <= {`CAPSC_SW1_INS, `CAPSC_SW2_NONE};
				end else if (!p1p2_ok) begin
					{sw1_q, sw2_q} <= {`CAPSC_SW1_P1P2, `CAPSC_SW2_NONE};
				end else if (early_q) begin
					{sw1_q, sw2_q} <= {`CAPSC_SW1_LEN, `CAPSC_SW2_NONE};
				end else if (toolkit_busy) begin
					{sw1_q, sw2_q} <= {`CAPSC_SW1_BUSY, `CAPSC_SW2_NONE};
				end else begin
					{sw1_q, sw2_q} <= code(outcome, detail, rsp_len);
				end
			end else if (st_q == S_SW && out_beat) begin
				sw_sel_q <= 1'b1;
			end
		end
	end

endmodule

// ==== rtl/capsc_cfg.svh ====
`ifndef CAPSC_CFG_SVH
`define CAPSC_CFG_SVH
`define CAPSC_PARAM_UNUSED 8'h00
`define CAPSC_LC_MAX 8'hff
`define CAPSC_LE_FULL 9'h100
`define CAPSC_SW1_OK 8'h90
`define CAPSC_SW1_PEND 8'h91
`define CAPSC_SW1_SESS 8'h92
`define CAPSC_SW1_BUSY 8'h93
`define CAPSC_SW1_WARN 8'h62
`define CAPSC_SW1_WARN2 8'h63
`define CAPSC_SW1_EXEC_KEEP 8'h64
`define CAPSC_SW1_EXEC_CHG 8'h65
`define CAPSC_SW1_LEN 8'h67
`define CAPSC_SW1_CLAF 8'h68
`define CAPSC_SW1_NALLOW 8'h69
`define CAPSC_SW1_PARAM 8'h6a
`define CAPSC_SW1_P1P2 8'h6b
`define CAPSC_SW1_INS 8'h6d
`define CAPSC_SW1_CLA 8'h6e
`define CAPSC_SW1_TECH 8'h6f
`define CAPSC_SW2_NONE 8'h00
`define CAPSC_SW2_MEM 8'h81
`define CAPSC_SW2_EOF 8'h82
`define CAPSC_SW2_INVAL 8'h83
`define CAPSC_SW2_TERM 8'h85
`define CAPSC_SW2_MORE 8'hf1
`define CAPSC_SW2_MORE_PEND 8'hf2
`define CAPSC_SW2_RESP 8'hf3
`define CAPSC_SW2_RETRY 4'hc
`define CAPSC_SW2_CHAN 8'h81
`define CAPSC_SW2_SM 8'h82
`endif

// ==== rtl/capsc_if.sv ====
`timescale 1ns/1ps
// Byte link between terminal and card, one byte per valid/ready beat
interface capsc_if;
	logic [7:0] cmd_data;
	logic cmd_valid;
	logic cmd_ready;
	logic [7:0] rsp_data;
	logic rsp_valid;
	logic rsp_ready;
	logic rsp_last;
	modport card(input cmd_data, input cmd_valid, output cmd_ready,
		output rsp_data, output rsp_valid, input rsp_ready,
		output rsp_last);
	modport term(output cmd_data, output cmd_valid, input cmd_ready,
		input rsp_data, input rsp_valid, output rsp_ready,
		input rsp_last);
endinterface

// ==== rtl/capsc_pkg.sv ====
package capsc_pkg;
	typedef logic [7:0] capsc_byte_t;
	// Outcome chosen by the application for one command
	typedef enum logic [4:0] {
		CAPSC_OK = 5'h00,
		CAPSC_OK_PEND = 5'h01,
		CAPSC_OK_SESS = 5'h02,
		CAPSC_BUSY = 5'h03,
		CAPSC_WARN_NONE = 5'h04,
		CAPSC_WARN_CORRUPT = 5'h05,
		CAPSC_WARN_EOF = 5'h06,
		CAPSC_WARN_INVAL = 5'h07,
		CAPSC_WARN_TERM = 5'h08,
		CAPSC_MORE_AVAIL = 5'h09,
		CAPSC_MORE_AVAIL_PEND = 5'h0a,
		CAPSC_RESP_AVAIL = 5'h0b,
		CAPSC_MORE_EXP = 5'h0c,
		CAPSC_MORE_EXP_PEND = 5'h0d,
		CAPSC_RETRY = 5'h0e,
		CAPSC_EXEC_KEEP = 5'h0f,
		CAPSC_EXEC_CHG = 5'h10,
		CAPSC_EXEC_MEM = 5'h11,
		CAPSC_LEN = 5'h12,
		CAPSC_P1P2 = 5'h13,
		CAPSC_TECH = 5'h14,
		CAPSC_CLAF = 5'h15,
		CAPSC_NALLOW = 5'h16,
		CAPSC_PARAM = 5'h17
	} capsc_outcome_e;
endpackage

// ==== rtl/capsc_term.sv ====
`timescale 1ns/1ps
`include "capsc_cfg.svh"
// Terminal end: sends one command in its chosen layout, collects response
module capsc_term (
	input wire logic clk,
	input wire logic rst,
	capsc_if.term link,
	input wire logic start,
	input wire logic use_lc,
	input wire logic use_le,
	input wire logic use_p1,
	input wire logic use_p2,
	input wire logic [7:0] cla,
	input wire logic [7:0] ins,
	input wire logic [7:0] p1,
	input wire logic [7:0] p2,
	input wire logic [7:0] lc,
	input wire logic [7:0] le,
	input wire logic [7:0] data_byte,
	output logic data_take,
	output logic [7:0] rx_byte,
	output logic rx_valid,
	output logic [7:0] sw1,
	output logic [7:0] sw2,
	output logic rsp_done,
	output logic busy
);

	typedef enum logic [4:0] {
		T_IDLE = 5'b00001,
		T_HDR = 5'b00010,
		T_DATA = 5'b00100,
		T_LE = 5'b01000,
		T_RSP = 5'b10000
	} capsc_tstate_e;

	capsc_tstate_e st_q;
	logic [2:0] idx_q;
	logic [7:0] cnt_q;
	logic [7:0] prev_q;
	logic got_q;
	logic [7:0] hdr_b;

	always_comb begin
		unique case (idx_q)
		3'h0: hdr_b = cla;
		3'h1: hdr_b = ins;
		3'h2: hdr_b = use_p1 ? p1 : `CAPSC_PARAM_UNUSED;
		3'h3: hdr_b = use_p2 ? p2 : `CAPSC_PARAM_UNUSED;
		default: hdr_b = lc;
		endcase
	end

	assign link.cmd_valid = (st_q == T_HDR) || (st_q == T_DATA) ||
		(st_q == T_LE);
	assign link.cmd_data = (st_q == T_DATA) ? data_byte :
		((st_q == T_LE) ? le : hdr_b);
	assign link.rsp_ready = (st_q == T_RSP);
	assign data_take = (st_q == T_DATA) && link.cmd_ready;
	assign busy = (st_q != T_IDLE);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_q <= T_IDLE;
			idx_q <= 3'h0;
			cnt_q <= 8'h00;
		end else begin
			unique case (st_q)
			T_IDLE: if (start) begin
				st_q <= T_HDR;
				idx_q <= 3'h0;
			end
			T_HDR: if (link.cmd_ready) begin
				idx_q <= idx_q + 3'h1;
				if (idx_q == 3'h4 || (idx_q == 3'h3 && !use_lc)) begin
					cnt_q <= lc;
					// Zero Lc carries no data; card refuses it the same way
					if (use_lc && lc != 8'h00) begin
						st_q <= T_DATA;
					end else begin
						st_q <= use_le ? T_LE : T_RSP;
					end
				end
			end
			T_DATA: if (link.cmd_ready) begin
				cnt_q <= cnt_q - 8'h01;
				if (cnt_q == 8'h01) begin
					st_q <= use_le ? T_LE : T_RSP;
				end
			end
			T_LE: if (link.cmd_ready) begin
				st_q <= T_RSP;
			end
			T_RSP: if (link.rsp_valid && link.rsp_last) begin
				st_q <= T_IDLE;
			end
			default: st_q <= T_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Response: hold one byte back so the last two become status
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			prev_q <= 8'h00;
			got_q <= 1'b0;
			rx_byte <= 8'h00;
			rx_valid <= 1'b0;
			sw1 <= 8'h00;
			sw2 <= 8'h00;
			rsp_done <= 1'b0;
		end else begin
			rx_valid <= 1'b0;
			rsp_done <= 1'b0;
			if (st_q == T_IDLE) begin
				got_q <= 1'b0;
			end
			if (st_q == T_RSP && link.rsp_valid) begin
				prev_q <= link.rsp_data;
				got_q <= !link.rsp_last;
				if (link.rsp_last) begin
					sw1 <= prev_q;
					sw2 <= link.rsp_data;
					rsp_done <= 1'b1;
				end else if (got_q) begin
					rx_byte <= prev_q;
					rx_valid <= 1'b1;
				end
			end
		end
	end

endmodule

// ==== verif/capsc_assertions.sv ====
`timescale 1ns/1ps
module capsc_assertions (
	input wire logic clk,
	input wire logic rst,
	input wire logic [7:0] cmd_data,
	input wire logic cmd_valid,
	input wire logic cmd_ready,
	input wire logic [7:0] rsp_data,
	input wire logic rsp_valid,
	input wire logic rsp_ready,
	input wire logic rsp_last
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	wire logic sw2_beat = rsp_valid && rsp_ready && rsp_last;
	////////////////////////////////////////////////////////////////
	chk_cmd_held_off: assert property (
		rsp_valid |-> !cmd_ready)
		else $error("card took command bytes while responding");
	chk_sw1_before_sw2: assert property (
		sw2_beat |-> $past(rsp_valid && rsp_ready && !rsp_last))
		else $error("status byte 2 without status byte 1");
	chk_idle_after_sw2: assert property (
		sw2_beat |=> !rsp_valid && cmd_ready)
		else $error("card not idle after status byte 2");
	// 256 data beats, then the two status beats
	chk_rsp_bounded: assert property (
		$rose(rsp_valid) |-> ##[1:257] sw2_beat)
		else $error("response longer than 258 beats");
	chk_sw1_known: assert property (
		sw2_beat |-> $past(rsp_data) inside {8'h90, 8'h91, 8'h92,
		8'h93, 8'h62, 8'h63, 8'h64, 8'h65, 8'h67, 8'h68, 8'h69,
		8'h6a, 8'h6b, 8'h6d, 8'h6e, 8'h6f})
		else $error("status byte 1 outside the known classes");
	chk_ok_sw2: assert property (
		sw2_beat && $past(rsp_data) == 8'h90 |-> rsp_data == 8'h00)
		else $error("normal completion with nonzero byte 2");
	chk_busy_sw2: assert property (
		sw2_beat && $past(rsp_data) == 8'h93 |-> rsp_data == 8'h00)
		else $error("busy status with nonzero byte 2");
	chk_warn_sw2: assert property (
		sw2_beat && $past(rsp_data) == 8'h62 |-> rsp_data inside
		{8'h00, 8'h81, 8'h82, 8'h83, 8'h85, 8'hf1, 8'hf2, 8'hf3})
		else $error("warning class with unknown byte 2");
	chk_more_sw2: assert property (
		sw2_beat && $past(rsp_data) == 8'h63 |->
		rsp_data inside {8'hf1, 8'hf2} || rsp_data[7:4] == 4'hc)
		else $error("second warning class with unknown byte 2");
	chk_exec_sw2: assert property (
		sw2_beat && $past(rsp_data) inside {8'h64, 8'h65} |->
		rsp_data == 8'h00 || $past(rsp_data) == 8'h65 &&
		rsp_data == 8'h81)
		else $error("execution error with unknown byte 2");
	chk_check_sw2: assert property (
		sw2_beat && $past(rsp_data) inside {8'h6b, 8'h6d, 8'h6e} |->
		rsp_data == 8'h00)
		else $error("checking error with nonzero byte 2");
	chk_cla_sw2: assert property (
		sw2_beat && $past(rsp_data) == 8'h68 |->
		rsp_data inside {8'h00, 8'h81, 8'h82})
		else $error("class function error with unknown byte 2");
endmodule

// ==== verif/card_apdu_length_and_status_coder_tb.sv ====
`timescale 1ns/1ps
module card_apdu_length_and_status_coder_tb;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic start = 1'b0;
	logic ul = 1'b0;
	logic ue = 1'b0;
	logic up = 1'b0;
	logic done = 1'b0;
	logic [5:0] vf = 6'h3f;
	logic [31:0] hb = 32'h80a45a3c;
	logic [7:0] lcv = 8'h00;
	logic [7:0] lev = 8'h00;
	logic [7:0] dt = 8'h00;
	logic [8:0] rl = 9'h000;
	capsc_pkg::capsc_outcome_e oc = capsc_pkg::CAPSC_OK;
	logic [7:0] c_p1, c_lc, cmd_b, rx_b, sw1, sw2;
	logic [7:0] c_cla, c_ins, c_p2, c_le;
	logic cmd_v, dtake, rtake, rx_v, rdone, hdr_v;
	logic c_busy, t_busy;
	int n_fail = 0;
	int num_checks = 0;
	int n_cmd = 0, n_rx = 0, n_tx = 0, n_rb = 0, b_cmd = 0, b_rx = 0;
	always #4 clk = ~clk;
	////////////////////////////////////////////////////////////////
	capsc_if link();
	capsc_card i_capsc_card (.clk(clk), .rst(rst), .link(link.card),
		.has_lc(ul), .has_le(ue), .cla(c_cla), .ins(c_ins),
		.p1(c_p1), .p2(c_p2),
		.lc(c_lc), .le(c_le), .hdr_valid(hdr_v), .cmd_byte(cmd_b),
		.cmd_byte_valid(cmd_v), .cla_ok(vf[5]), .cla_chan_ok(vf[4]),
		.cla_sm_ok(vf[3]), .ins_ok(vf[2]), .p1p2_ok(vf[1]),
		.toolkit_busy(!vf[0]), .done(done), .outcome(oc), .detail(dt),
		.rsp_len(rl), .rsp_byte(8'(n_rb) ^ 8'ha5),
		.rsp_byte_take(rtake), .busy(c_busy));
	capsc_term i_capsc_term (.clk(clk), .rst(rst), .link(link.term),
		.start(start), .use_lc(ul), .use_le(ue), .use_p1(up),
		.use_p2(up), .cla(hb[31:24]), .ins(hb[23:16]), .p1(hb[15:8]),
		.p2(hb[7:0]), .lc(lcv), .le(lev), .data_byte(8'(n_tx) ^ 8'h3c),
		.data_take(dtake), .rx_byte(rx_b), .rx_valid(rx_v), .sw1(sw1),
		.sw2(sw2), .rsp_done(rdone), .busy(t_busy));
	capsc_assertions i_capsc_assertions (.clk(clk), .rst(rst),
		.cmd_data(link.cmd_data), .cmd_valid(link.cmd_valid),
		.cmd_ready(link.cmd_ready), .rsp_data(link.rsp_data),
		.rsp_valid(link.rsp_valid), .rsp_ready(link.rsp_ready),
		.rsp_last(link.rsp_last));
	////////////////////////////////////////////////////////////////
	task automatic chk(input logic [15:0] g, input logic [15:0] x);
		num_checks++;
		if (g !== x) begin
			n_fail++;
			$display("wrong value t=%0t got %h exp %h", $time, g, x);
		end
	endtask
	// Byte streams are numbered so order and loss both show up
	always @(posedge clk) begin
		if (dtake) n_tx <= n_tx + 1;
		if (rtake) n_rb <= n_rb + 1;
		if (cmd_v) begin
			chk(16'(cmd_b), 16'(8'(n_cmd) ^ 8'h3c));
			n_cmd <= n_cmd + 1;
		end
		if (rx_v) begin
			chk(16'(rx_b), 16'(8'(n_rx) ^ 8'ha5));
			n_rx <= n_rx + 1;
		end
	end
	// One command; the application answers as soon as asked
	task automatic go(input logic l, input logic e,
		input logic [7:0] lc, input logic [7:0] le, input logic [8:0] r);
		int k;
		@(negedge clk);
		{ul, ue, lcv, lev, rl} = {l, e, lc, le, r};
		b_cmd = n_cmd;
		b_rx = n_rx;
		start = 1'b1;
		@(negedge clk);
		start = 1'b0;
		chk(16'(t_busy), 16'h0001);
		for (k = 0; k < 2000 && !rdone; k++) begin
			done = hdr_v && !done;
			@(negedge clk);
		end
		done = 1'b0;
		if (!rdone) chk(16'h0000, 16'h0001);
		chk(16'({c_busy, t_busy}), 16'h0000);
	endtask
	////////////////////////////////////////////////////////////////
	task automatic s_hdr;
		go(1'b0, 1'b0, 8'h00, 8'h00, 9'h005);
		chk({sw1, sw2}, 16'h9000);
		chk(16'(n_rx - b_rx), 16'h0000);
		chk({c_p1, c_lc}, 16'h0000);
	endtask
	task automatic s_len;
		logic [7:0] t[3] = '{8'h01, 8'hff, 8'h00};
		for (int i = 0; i < 3; i++) begin
			go(1'b1, 1'b0, t[i], 8'h00, 9'h000);
			chk({sw1, sw2}, (t[i] != 8'h00) ? 16'h9000 : 16'h6700);
			chk(16'(n_cmd - b_cmd), 16'(t[i]));
		end
	endtask
	task automatic s_le;
		up = 1'b1;
		go(1'b0, 1'b1, 8'h00, 8'h00, 9'h100);
		chk(16'(n_rx - b_rx), 16'h0100);
		chk(16'(c_p1), 16'h005a);
		go(1'b1, 1'b1, 8'h03, 8'h04, 9'h00a);
		chk(16'(n_rx - b_rx), 16'h0004);
		chk({sw1, sw2}, 16'h9000);
		chk({c_cla, c_ins}, 16'h80a4);
		chk({c_p2, c_le}, 16'h3c04);
		go(1'b0, 1'b1, 8'h00, 8'h00, 9'h001);
		chk(16'(n_rx - b_rx), 16'h0001);
		up = 1'b0;
	endtask
	// Failing header checks: first failure wins, no response data
	task automatic s_verdict;
		logic [15:0] x[6] = '{16'h6e00, 16'h6881, 16'h6882, 16'h6d00,
			16'h6b00, 16'h9300};
		for (int i = 0; i < 6; i++) begin
			vf = 6'h3f << (6 - i);
			go(1'b1, 1'b1, 8'h02, 8'h04, 9'h004);
			chk({sw1, sw2}, x[i]);
			chk(16'(n_rx - b_rx), 16'h0000);
			chk(16'(n_cmd - b_cmd), 16'h0002);
		end
		go(1'b1, 1'b0, 8'h00, 8'h00, 9'h000);
		chk({sw1, sw2}, 16'h6700);
		vf = 6'h3f;
	endtask
	task automatic s_codes;
		logic [15:0] x[24] = '{16'h9000, 16'h9123, 16'h9282, 16'h9300,
			16'h6200, 16'h6281, 16'h6282, 16'h6283, 16'h6285, 16'h62f1,
			16'h62f2, 16'h62f3, 16'h63f1, 16'h63f2, 16'h63c2, 16'h6400,
			16'h6500, 16'h6581, 16'h6782, 16'h6b00, 16'h6f82, 16'h6882,
			16'h6982, 16'h6a82};
		dt = 8'h82;
		for (int i = 0; i < 24; i++) begin
			oc = capsc_pkg::capsc_outcome_e'(i);
			go(1'b0, 1'b0, 8'h00, 8'h00, 9'h023);
			chk({sw1, sw2}, x[i]);
		end
		oc = capsc_pkg::CAPSC_OK;
		go(1'b0, 1'b0, 8'h00, 8'h00, 9'h000);
		chk({sw1, sw2}, 16'h9000);
	endtask
	////////////////////////////////////////////////////////////////
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	// Whole run is about a thousand cycles; this leaves wide margin
	initial begin
		#400000;
		n_fail++;
		report_and_stop;
	end
	initial begin
		repeat (12) @(posedge clk);
		@(negedge clk);
		rst = 1'b0;
		s_hdr;
		s_len;
		s_le;
		s_verdict;
		s_codes;
		report_and_stop;
	end
endmodule
